// File: hw/vid_pkg.sv
package vid_pkg;

   // Register byte offsets on the AXI4-Lite slave
   localparam logic [11:0] OFS_INTERRUPT_STATUS = 12'h000;
   localparam logic [11:0] OFS_INTERRUPT_ENABLE = 12'h004;
   localparam logic [11:0] OFS_SWAP_CAPTURE = 12'h008;
   localparam logic [11:0] OFS_DMA_CONFIG = 12'h00c;

   // Status bit positions
   localparam int BIT_REQUEST_LEVEL_FOUR = 7;
   localparam int BIT_REQUEST_LEVEL_THREE = 6;
   localparam int BIT_REQUEST_LEVEL_TWO = 5;
   localparam int BIT_REQUEST_LEVEL_ONE = 4;
   localparam int BIT_REMOTE_CORRECTABLE = 2;
   localparam int BIT_REMOTE_UNCORRECTABLE = 1;
   localparam int BIT_LOCAL_PARITY = 0;

   // Width of the implemented status and enable field
   localparam int STATUS_W = 8;

   // Bits that exist in the status and enable registers; bit 3 is unused
   localparam logic [7:0] STATUS_IMPL_MASK = 8'hf7;

   // DMA configuration field positions
   localparam int DMA_LEVEL_LSB = 16;
   localparam int DMA_LEVEL_MSB = 17;
   localparam int DMA_INTR_EN_BIT = 9;

   // DMA done level codes
   localparam logic [1:0] DMA_CODE_LEVEL_ONE = 2'h0;
   localparam logic [1:0] DMA_CODE_LEVEL_TWO = 2'h1;
   localparam logic [1:0] DMA_CODE_LEVEL_THREE = 2'h2;
   localparam logic [1:0] DMA_CODE_LEVEL_FOUR = 2'h3;

   // Values after reset
   localparam logic [7:0] RST_INTERRUPT_STATUS = 8'h00;
   localparam logic [7:0] RST_INTERRUPT_ENABLE = 8'h00;
   localparam logic [31:0] RST_SWAP_CAPTURE = 32'h0000_0000;
   localparam logic [1:0] RST_DMA_LEVEL = 2'h0;
   localparam logic RST_DMA_INTR_EN = 1'b0;

   // AXI response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: hw/vid_irq_swap.sv
// Operation
// - Request raised when enabled status bit set
// - Bus reset clears all status bits
// - Request holds until software clears status bit
// - DMA level four request sets bit 7
// - DMA level three request sets bit 6
// - Transaction or DMA level two sets bit 5
// - Transaction or DMA level one sets bit 4
// - Remote correctable ECC error sets bit 2
// - Remote uncorrectable ECC error sets bit 1
// - Local buffer parity error sets bit 0
// - Enable bit one lets status bit request
// - Cleared enable bit blocks its source
// - Enable bits read-write, reset to zero
// - Swap capture register ignores software writes
// - Capture on every buffer write, and on each buffer read without a write
// - Write capture holds byte swapper output
// - Read capture holds raw RAM word
// - DMA level code selects request level
// - DMA interrupt enable gates DMA completion requests
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module vid_irq_swap #(
   parameter int ADDR_W = 12
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic dma_done,
   input wire logic tc_request_level_one,
   input wire logic tc_request_level_two,
   input wire logic remote_correctable_error,
   input wire logic remote_uncorrectable_error,
   input wire logic local_buffer_parity_error,
   input wire logic buffer_ram_write,
   input wire logic [31:0] swap_out_data,
   input wire logic buffer_ram_read,
   input wire logic [31:0] buffer_ram_rdata,
   output logic bus_irq_req,
   output logic [2:0] bus_irq_level
);

   // Write channel holding state
   logic aw_hold_r;
   logic w_hold_r;
   logic [ADDR_W-1:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic awready_r;
   logic wready_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   // Read channel state
   logic arready_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   // Block registers
   logic [vid_pkg::STATUS_W-1:0] status_r;
   logic [vid_pkg::STATUS_W-1:0] enable_r;
   logic [31:0] swap_capture_r;
   logic [1:0] dma_level_r;
   logic dma_intr_en_r;
   logic irq_r;
   logic [2:0] irq_level_r;
   // Combinational helpers
   logic aw_take;
   logic w_take;
   logic ar_take;
   logic do_wr;
   logic aw_hold_nxt;
   logic w_hold_nxt;
   logic bvalid_nxt;
   logic rvalid_nxt;
   logic [11:0] wr_ofs;
   logic [11:0] rd_ofs;
   logic wr_hit;
   logic rd_hit;
   logic [31:0] rd_value;
   logic [vid_pkg::STATUS_W-1:0] set_v;
   logic [vid_pkg::STATUS_W-1:0] clr_v;
   logic [vid_pkg::STATUS_W-1:0] pending;
   logic dma_fire;
   logic [2:0] irq_level_nxt;
   // Handshakes; a write is performed once both halves are held
   assign aw_take = s_axi_awvalid & awready_r;
   assign w_take = s_axi_wvalid & wready_r;
   assign ar_take = s_axi_arvalid & arready_r;
   assign do_wr = aw_hold_r & w_hold_r & ~bvalid_r;
   assign aw_hold_nxt = (aw_hold_r | aw_take) & ~do_wr;
   assign w_hold_nxt = (w_hold_r | w_take) & ~do_wr;
   assign bvalid_nxt = do_wr | (bvalid_r & ~s_axi_bready);
   assign rvalid_nxt = ar_take | (rvalid_r & ~s_axi_rready);

   // Word-aligned offsets; the two low address bits are ignored
   assign wr_ofs = {awaddr_r[11:2], 2'b00};
   assign rd_ofs = {s_axi_araddr[11:2], 2'b00};
   // Address capture for writes; aw and w may arrive in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r <= 1'b0;
         awaddr_r <= '0;
      end else begin
         aw_hold_r <= aw_hold_nxt;
         if (aw_take) begin
            awaddr_r <= s_axi_awaddr;
         end
      end
   end

   // Data capture for writes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_hold_r <= 1'b0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end else begin
         w_hold_r <= w_hold_nxt;
         if (w_take) begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
      end
   end

   // Ready stays low while a half is parked or a response is owed
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b0;
         wready_r <= 1'b0;
      end else begin
         awready_r <= ~aw_hold_nxt & ~bvalid_nxt;
         wready_r <= ~w_hold_nxt & ~bvalid_nxt;
      end
   end

   // Write decode
   always_comb begin
      wr_hit = 1'b0;
      case (wr_ofs)
         vid_pkg::OFS_INTERRUPT_STATUS: wr_hit = 1'b1;
         vid_pkg::OFS_INTERRUPT_ENABLE: wr_hit = 1'b1;
         vid_pkg::OFS_SWAP_CAPTURE: wr_hit = 1'b1;
         vid_pkg::OFS_DMA_CONFIG: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // Write response; unmapped offsets answer SLVERR and change nothing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r <= vid_pkg::RESP_OKAY;
      end else begin
         bvalid_r <= bvalid_nxt;
         if (do_wr) begin
            bresp_r <= wr_hit ? vid_pkg::RESP_OKAY : vid_pkg::RESP_SLVERR;
         end
      end
   end

   // Read decode; bits above the implemented fields read as zero
   always_comb begin
      rd_value = 32'h0000_0000;
      rd_hit = 1'b1;
      case (rd_ofs)
         vid_pkg::OFS_INTERRUPT_STATUS: rd_value[vid_pkg::STATUS_W-1:0] = status_r;
         vid_pkg::OFS_INTERRUPT_ENABLE: rd_value[vid_pkg::STATUS_W-1:0] = enable_r;
         vid_pkg::OFS_SWAP_CAPTURE: rd_value = swap_capture_r;
         vid_pkg::OFS_DMA_CONFIG: begin
            rd_value[vid_pkg::DMA_LEVEL_MSB:vid_pkg::DMA_LEVEL_LSB] = dma_level_r;
            rd_value[vid_pkg::DMA_INTR_EN_BIT] = dma_intr_en_r;
         end
         default: rd_hit = 1'b0;
      endcase
   end

   // Read channel; data is sampled at the address handshake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= vid_pkg::RESP_OKAY;
      end else begin
         arready_r <= ~rvalid_nxt;
         rvalid_r <= rvalid_nxt;
         if (ar_take) begin
            rdata_r <= rd_value;
            rresp_r <= rd_hit ? vid_pkg::RESP_OKAY : vid_pkg::RESP_SLVERR;
         end
      end
   end

   // DMA completion only requests when its enable is set
   assign dma_fire = dma_done & dma_intr_en_r;
   // Event sources per status bit; bit 3 has no source
   always_comb begin
      set_v = '0;
      set_v[vid_pkg::BIT_REQUEST_LEVEL_FOUR] = dma_fire
         & (dma_level_r == vid_pkg::DMA_CODE_LEVEL_FOUR);
      set_v[vid_pkg::BIT_REQUEST_LEVEL_THREE] = dma_fire & (dma_level_r == vid_pkg::DMA_CODE_LEVEL_THREE);
      set_v[vid_pkg::BIT_REQUEST_LEVEL_TWO] = tc_request_level_two
         | (dma_fire & (dma_level_r == vid_pkg::DMA_CODE_LEVEL_TWO));
      set_v[vid_pkg::BIT_REQUEST_LEVEL_ONE] = tc_request_level_one
         | (dma_fire & (dma_level_r == vid_pkg::DMA_CODE_LEVEL_ONE));
      set_v[vid_pkg::BIT_REMOTE_CORRECTABLE] = remote_correctable_error;
      set_v[vid_pkg::BIT_REMOTE_UNCORRECTABLE] = remote_uncorrectable_error;
      set_v[vid_pkg::BIT_LOCAL_PARITY] = local_buffer_parity_error;
   end

   // Write-one-to-clear strobe from byte lane 0 of a status write
   assign clr_v = (do_wr && wr_ofs == vid_pkg::OFS_INTERRUPT_STATUS && wstrb_r[0])
      ? wdata_r[vid_pkg::STATUS_W-1:0] : '0;
   // Sticky status bits; a set in the clearing cycle wins so no event is lost
   generate
      for (genvar k = 0; k < vid_pkg::STATUS_W; k++) begin : g_status
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               status_r[k] <= vid_pkg::RST_INTERRUPT_STATUS[k];
            end else if (!vid_pkg::STATUS_IMPL_MASK[k]) begin
               status_r[k] <= 1'b0;
            end else if (set_v[k]) begin
               status_r[k] <= 1'b1;
            end else if (clr_v[k]) begin
               status_r[k] <= 1'b0;
            end
         end
      end
   endgenerate

   // Enable register, software read-write through byte lane 0
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enable_r <= vid_pkg::RST_INTERRUPT_ENABLE;
      end else if (do_wr && wr_ofs == vid_pkg::OFS_INTERRUPT_ENABLE && wstrb_r[0]) begin
         enable_r <= wdata_r[vid_pkg::STATUS_W-1:0] & vid_pkg::STATUS_IMPL_MASK;
      end
   end

   // DMA completion configuration
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dma_level_r <= vid_pkg::RST_DMA_LEVEL;
         dma_intr_en_r <= vid_pkg::RST_DMA_INTR_EN;
      end else if (do_wr && wr_ofs == vid_pkg::OFS_DMA_CONFIG) begin
         if (wstrb_r[2]) begin
            dma_level_r <= wdata_r[vid_pkg::DMA_LEVEL_MSB:vid_pkg::DMA_LEVEL_LSB];
         end
         if (wstrb_r[1]) begin
            dma_intr_en_r <= wdata_r[vid_pkg::DMA_INTR_EN_BIT];
         end
      end
   end

   // Swap capture; bus writes never reach it, a write beats a read in one cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         swap_capture_r <= vid_pkg::RST_SWAP_CAPTURE;
      end else if (buffer_ram_write) begin
         swap_capture_r <= swap_out_data;
      end else if (buffer_ram_read) begin
         swap_capture_r <= buffer_ram_rdata;
      end
   end

   // Only enabled sources reach the request; acknowledge has no path here
   assign pending = status_r & enable_r;
   // Highest pending request level, zero when idle
   always_comb begin
      irq_level_nxt = 3'h0;
      if (pending[vid_pkg::BIT_REQUEST_LEVEL_FOUR]) begin
         irq_level_nxt = 3'h4;
      end else if (pending[vid_pkg::BIT_REQUEST_LEVEL_THREE]) begin
         irq_level_nxt = 3'h3;
      end else if (pending[vid_pkg::BIT_REQUEST_LEVEL_TWO]) begin
         irq_level_nxt = 3'h2;
      end else if (pending[vid_pkg::BIT_REQUEST_LEVEL_ONE]) begin
         irq_level_nxt = 3'h1;
      end
   end

   // Registered request; error bits request without a level
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_r <= 1'b0;
         irq_level_r <= 3'h0;
      end else begin
         irq_r <= |pending;
         irq_level_r <= irq_level_nxt;
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign bus_irq_req = irq_r;
   assign bus_irq_level = irq_level_r;

   // Request follows any enabled pending bit one edge later
   AST_IRQ_FOLLOWS: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (|(status_r & enable_r)) |=> bus_irq_req)
      else $error("Request not raised for enabled pending status");
   // A disabled source never shows on the request
   AST_IRQ_BLOCKED: assert property (
      @(posedge aclk) disable iff (!aresetn)
      ((status_r & enable_r) == '0) |=> !bus_irq_req)
      else $error("Request raised with no enabled pending status");
   // Reset empties status and enable
   AST_RESET_CLEARS: assert property (
      @(posedge aclk)
      !aresetn |=> (status_r == '0 && enable_r == '0 && !bus_irq_req))
      else $error("Status or enable not cleared by reset");
   // A set bit persists until a write of one to it
   AST_STATUS_STICKY: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (status_r[vid_pkg::BIT_REQUEST_LEVEL_ONE] && !clr_v[vid_pkg::BIT_REQUEST_LEVEL_ONE])
      |=> status_r[vid_pkg::BIT_REQUEST_LEVEL_ONE])
      else $error("Status bit dropped without a clear");
   // DMA level code three lands in bit 7
   AST_DMA_LEVEL_FOUR: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (dma_done && dma_intr_en_r && dma_level_r == vid_pkg::DMA_CODE_LEVEL_FOUR
         && !status_r[vid_pkg::BIT_REQUEST_LEVEL_THREE])
      |=> status_r[vid_pkg::BIT_REQUEST_LEVEL_FOUR] && !status_r[vid_pkg::BIT_REQUEST_LEVEL_THREE])
      else $error("DMA level four did not set bit 7");
   // DMA level code two lands in bit 6
   AST_DMA_LEVEL_THREE: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (dma_done && dma_intr_en_r && dma_level_r == vid_pkg::DMA_CODE_LEVEL_THREE)
      |=> status_r[vid_pkg::BIT_REQUEST_LEVEL_THREE])
      else $error("DMA level three did not set bit 6");
   // Transaction requests land in bits 5 and 4
   AST_TC_LEVELS: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (tc_request_level_two |=> status_r[vid_pkg::BIT_REQUEST_LEVEL_TWO])
      and (tc_request_level_one |=> status_r[vid_pkg::BIT_REQUEST_LEVEL_ONE]))
      else $error("Transaction request did not set its status bit");
   AST_ERRORS_SET: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (local_buffer_parity_error |=> status_r[vid_pkg::BIT_LOCAL_PARITY])
      and (remote_uncorrectable_error |=> status_r[vid_pkg::BIT_REMOTE_UNCORRECTABLE]))
      else $error("Error event did not set its status bit");
   // No DMA request while its enable is off
   AST_DMA_GATED: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (!dma_intr_en_r && !tc_request_level_one && !status_r[vid_pkg::BIT_REQUEST_LEVEL_ONE])
      |=> !status_r[vid_pkg::BIT_REQUEST_LEVEL_ONE])
      else $error("DMA completion set status while disabled");
   // Unused bit stays zero
   AST_UNUSED_ZERO: assert property (
      @(posedge aclk) disable iff (!aresetn)
      1'b1 |-> status_r[3] == 1'b0 && enable_r[3] == 1'b0)
      else $error("Unused status bit became set");
   // Capture holds swapper output after a RAM write
   AST_CAPTURE_WRITE: assert property (
      @(posedge aclk) disable iff (!aresetn)
      buffer_ram_write |=> swap_capture_r == $past(swap_out_data))
      else $error("Write capture does not match swapper output");
   // Capture holds raw word after a RAM read
   AST_CAPTURE_READ: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (buffer_ram_read && !buffer_ram_write) |=> swap_capture_r == $past(buffer_ram_rdata))
      else $error("Read capture does not match RAM word");
   // Without RAM traffic the capture stands, bus writes included
   AST_CAPTURE_STABLE: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (!buffer_ram_read && !buffer_ram_write) |=> $stable(swap_capture_r))
      else $error("Capture changed without RAM access");
   // Response arrives two edges after both halves are taken together
   AST_WRITE_RESP: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (aw_take && w_take && !aw_hold_r && !w_hold_r) |=> ##1 s_axi_bvalid)
      else $error("Write response not on time");

endmodule

// File: dv/vid_irq_handler.sv
`timescale 1ns/1ps
module vid_irq_handler (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic bus_irq_req,
   input wire logic [2:0] bus_irq_level,
   output int n_raised,
   output logic [2:0] taken_level
);
   logic req_d_r;

   // Handler only notes each fresh request; it has no way to drop it, software clears the source
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         req_d_r <= 1'b0;
         n_raised <= 0;
         taken_level <= 3'h0;
      end else begin
         req_d_r <= bus_irq_req;
         if (bus_irq_req && !req_d_r) begin
            n_raised <= n_raised + 1;
            taken_level <= bus_irq_level;
         end
      end
   end
endmodule

// File: dv/vme_io_interrupt_and_swap_diag_tb.sv
`timescale 1ns/1ps
module vme_io_interrupt_and_swap_diag_tb;
   localparam logic [11:0] ST = vid_pkg::OFS_INTERRUPT_STATUS;
   localparam logic [11:0] EN = vid_pkg::OFS_INTERRUPT_ENABLE;
   localparam logic [11:0] SC = vid_pkg::OFS_SWAP_CAPTURE;
   localparam logic [11:0] DC = vid_pkg::OFS_DMA_CONFIG;
   localparam logic [1:0] OK = vid_pkg::RESP_OKAY;
   localparam logic [1:0] ERR = vid_pkg::RESP_SLVERR;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, swap_d, ram_d;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [7:0] ev;
   logic [2:0] lvl, taken_level;
   int n_raised, exp_raised, n_fail, total_checks, i, code;
   integer seed;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   int bt[6] = '{0, 4, 5, 2, 1, 0};
   logic [2:0] lv[6] = '{3'h0, 3'h1, 3'h2, 3'h0, 3'h0, 3'h0};

   vid_irq_swap #(.ADDR_W(12)) dut_u (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .dma_done(ev[0]), .tc_request_level_one(ev[1]), .tc_request_level_two(ev[2]),
      .remote_correctable_error(ev[3]), .remote_uncorrectable_error(ev[4]),
      .local_buffer_parity_error(ev[5]), .buffer_ram_write(ev[6]), .swap_out_data(swap_d),
      .buffer_ram_read(ev[7]), .buffer_ram_rdata(ram_d), .bus_irq_req(irq), .bus_irq_level(lvl));

   vid_irq_handler handler_u (.aclk(aclk), .aresetn(aresetn), .bus_irq_req(irq),
      .bus_irq_level(lvl), .n_raised(n_raised), .taken_level(taken_level));

   // Free-running 200 MHz clock
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic timeout();
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, 32'h0, 32'h1);
      tally_and_finish();
   endtask

   function automatic logic [33:0] okv(input logic [31:0] d);
      return {OK, d};
   endfunction

   // Write: both channels offered together, each dropped when taken, bready held until bvalid
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] resp);
      int k;
      bq.push_back(resp);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) begin
            bready <= 1'b0;
            break;
         end
      end
      if (k == 50) timeout();
      @(posedge aclk); // Spare edge so a following call never drives bready twice in one step
   endtask

   // Read: rready held from the start until rvalid is sampled
   task automatic rd(input logic [11:0] a, input logic [33:0] exp);
      int k;
      rq.push_back(exp);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) begin
            rready <= 1'b0;
            break;
         end
      end
      if (k == 50) timeout();
      @(posedge aclk); // Spare edge so a following call never drives rready twice in one step
   endtask

   // Two edges per pulse so the same strobe is never driven twice in one time step
   task automatic pulse(input int s);
      ev[s] <= 1'b1;
      @(posedge aclk);
      ev[s] <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic do_reset();
      aresetn <= 1'b0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
   endtask

   // Response monitor: oldest note is compared when a response completes
   always @(posedge aclk) begin
      if (bvalid && bready && bq.size() > 0) check(34'(bresp), 34'(bq.pop_front()));
      if (rvalid && rready && rq.size() > 0) check({rresp, rdata}, rq.pop_front());
   end

   initial begin
      seed = 32'h1c734be5;
      {aresetn, awvalid, wvalid, bready, arvalid, rready, ev} = '0;
      {awaddr, araddr, wdata, swap_d, ram_d} = '0;
      wstrb = 4'hf;
      exp_raised = 0;
      do_reset();
      // Pending request and enable must both vanish on a mid-run reset
      wr(EN, 32'h01, OK);
      pulse(5);
      repeat (2) @(posedge aclk);
      check(34'(irq), 34'h1);
      do_reset();
      check(34'(irq), 34'h0);
      rd(ST, okv(32'h0));
      rd(EN, okv(32'h0));
      rd(SC, okv(32'h0));
      rd(DC, okv(32'h0));
      rd(12'h010, {ERR, 32'h0});
      wr(12'h010, 32'hffffffff, ERR);
      $display("test reset_and_unmapped done");
      // Only implemented bits hold; unused status bits never set
      wr(EN, 32'hffffffff, OK);
      rd(EN, okv(32'hf7));
      // Without byte lane 0 the enable write must leave the register alone
      wstrb <= 4'he;
      wr(EN, 32'h0, OK);
      wstrb <= 4'hf;
      rd(EN, okv(32'hf7));
      wr(ST, 32'hffffffff, OK);
      rd(ST, okv(32'h0));
      check(34'(irq), 34'h0);
      $display("test unused_bits done");
      // Each non-DMA source sets its own bit, requests, and clears by writing one
      for (i = 1; i < 6; i++) begin
         pulse(i);
         repeat (2) @(posedge aclk);
         check(34'(irq), 34'h1);
         check(34'(lvl), 34'(lv[i]));
         rd(ST, okv(32'h1 << bt[i]));
         wr(ST, 32'h1 << bt[i], OK);
         @(posedge aclk);
         check(34'(irq), 34'h0);
         exp_raised++;
      end
      $display("test sources done");
      // Every DMA level code, then completion with the DMA interrupt disabled
      for (code = 0; code < 4; code++) begin
         wr(DC, (32'(code) << 16) | 32'h200, OK);
         rd(DC, okv((32'(code) << 16) | 32'h200));
         pulse(0);
         repeat (2) @(posedge aclk);
         check(34'(lvl), 34'(code + 1));
         check(34'(taken_level), 34'(code + 1));
         rd(ST, okv(32'h10 << code));
         wr(ST, 32'h10 << code, OK);
         exp_raised++;
      end
      wr(DC, 32'h30000, OK);
      pulse(0);
      repeat (2) @(posedge aclk);
      check(34'(irq), 34'h0);
      rd(ST, okv(32'h0));
      $display("test dma_levels done");
      // Mask blocks a pending source; request then holds until its own bit is cleared
      wr(EN, 32'h0, OK);
      pulse(1);
      repeat (3) @(posedge aclk);
      check(34'(irq), 34'h0);
      rd(ST, okv(32'h10));
      wr(EN, 32'h10, OK);
      repeat (2) @(posedge aclk);
      check(34'(irq), 34'h1);
      exp_raised++;
      wr(ST, 32'h20, OK);
      repeat (20) @(posedge aclk);
      check(34'(irq), 34'h1);
      wr(ST, 32'h10, OK);
      @(posedge aclk);
      check(34'(irq), 34'h0);
      $display("test mask_and_hold done");
      // Capture takes swapper output on writes and raw word on reads, ignores bus writes
      for (i = 0; i < 4; i++) begin
         swap_d <= $random(seed);
         ram_d <= $random(seed);
         pulse(6);
         rd(SC, okv(swap_d));
         pulse(7);
         swap_d <= $random(seed);
         rd(SC, okv(ram_d));
         wr(SC, ~ram_d, OK);
         rd(SC, okv(ram_d));
      end
      $display("test swap_capture done");
      check(34'(n_raised), 34'(exp_raised));
      tally_and_finish();
   end
endmodule
